// File: rtl/sac_atten_ctrl.sv
// Purpose: controller that drives the attenuator control pins
// Assumes: one request at a time, taken with valid and ready
// Notes:   sclk is divided from i_mclk and idles low
`timescale 1ns/100ps
module sac_atten_ctrl
  import sac_pkg::*;
#(
  parameter int PWRUP_CYC = PWRUP_CYC_DFLT
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_req_valid,
  input  wire logic [sac_pkg::ATTEN_W-1:0] i_req_word,
  input  wire sac_pkg::sac_mode_t     i_req_mode,
  input  wire logic                   i_req_direct,
  output logic                        o_req_ready,
  output logic                        o_done,
  sac_link_if.ctrl                    link
);
  import sac_pkg::*;

  typedef enum logic [2:0] {
    ST_PWRUP, ST_IDLE, ST_BIT_LO, ST_BIT_HI,
    ST_SETUP, ST_LATCH, ST_GAP, ST_DIRECT
  } sac_state_t;

  sac_state_t         state_ff;
  logic [CNT_W-1:0]   cnt_ff;
  logic [2:0]         bit_ff;
  logic [ATTEN_W-1:0] sreg_ff;
  logic               mode_ff;
  logic               le_ff;
  logic               sclk_ff;
  logic               sdata_ff;
  logic [ATTEN_W-1:0] pbits_ff;
  logic               done_ff;

  wire is_serial;
  wire take;
  wire cnt_zero;
  assign is_serial = (i_req_mode == SAC_SERIAL);
  // in direct mode only another direct word may be taken without a gap
  assign o_req_ready = (state_ff == ST_IDLE) |
                       ((state_ff == ST_DIRECT) & ~is_serial & i_req_direct);
  assign take     = i_req_valid & o_req_ready;
  assign cnt_zero = (cnt_ff == '0);

  localparam logic [CNT_W-1:0] HALF_LD  = CNT_W'(SCK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] LEH_LD   = CNT_W'(LE_HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] SPACE_LD = CNT_W'(LE_SPACE_CYC - 1);
  localparam logic [CNT_W-1:0] PWR_LD   = CNT_W'(PWRUP_CYC);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_PWRUP;
      cnt_ff   <= PWR_LD;
      bit_ff   <= '0;
      sreg_ff  <= ATTEN_ZERO;
      mode_ff  <= 1'b0;
      le_ff    <= 1'b0;
      sclk_ff  <= 1'b0;
      sdata_ff <= 1'b0;
      pbits_ff <= ATTEN_ZERO;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      cnt_ff  <= cnt_zero ? cnt_ff : cnt_ff - CNT_W'(1);
      unique case (state_ff)
        ST_PWRUP: begin
          if (cnt_zero) begin
            state_ff <= ST_SETUP;
          end
        end
        ST_IDLE, ST_DIRECT: begin
          if (take && is_serial) begin
            mode_ff  <= 1'b1;
            le_ff    <= 1'b0;
            pbits_ff <= ATTEN_ZERO;
            sreg_ff  <= i_req_word;
            sdata_ff <= i_req_word[ATTEN_MSB];
            bit_ff   <= 3'(ATTEN_W - 1);
            cnt_ff   <= HALF_LD;
            state_ff <= ST_BIT_LO;
          end else if (take && i_req_direct) begin
            mode_ff  <= 1'b0;
            le_ff    <= 1'b1;
            sdata_ff <= 1'b0;
            pbits_ff <= i_req_word;
            done_ff  <= 1'b1;
            state_ff <= ST_DIRECT;
          end else if (take) begin
            mode_ff  <= 1'b0;
            le_ff    <= 1'b0;
            sdata_ff <= 1'b0;
            pbits_ff <= i_req_word;
            state_ff <= ST_SETUP;
          end else if (state_ff == ST_DIRECT && i_req_valid) begin
            // leaving direct mode: drop latch and keep the spacing first
            le_ff    <= 1'b0;
            cnt_ff   <= SPACE_LD;
            state_ff <= ST_GAP;
          end
        end
        ST_BIT_LO: begin
          if (cnt_zero) begin
            sclk_ff  <= 1'b1;
            cnt_ff   <= HALF_LD;
            state_ff <= ST_BIT_HI;
          end
        end
        ST_BIT_HI: begin
          if (cnt_zero) begin
            sclk_ff <= 1'b0;
            cnt_ff  <= HALF_LD;
            if (bit_ff == 3'h0) begin
              sdata_ff <= 1'b0;
              state_ff <= ST_SETUP;
            end else begin
              sreg_ff  <= {sreg_ff[ATTEN_W-2:0], 1'b0};
              sdata_ff <= sreg_ff[ATTEN_MSB-1];
              bit_ff   <= bit_ff - 3'h1;
              state_ff <= ST_BIT_LO;
            end
          end
        end
        ST_SETUP: begin
          le_ff    <= 1'b1;
          cnt_ff   <= LEH_LD;
          state_ff <= ST_LATCH;
        end
        ST_LATCH: begin
          if (cnt_zero) begin
            le_ff    <= 1'b0;
            cnt_ff   <= SPACE_LD;
            state_ff <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (cnt_zero) begin
            done_ff  <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // every pin comes from a flop with a reset value, never left floating
  assign link.ser_mode            = mode_ff;
  assign link.latch_enable_in     = le_ff;
  assign link.sclk                = sclk_ff;
  assign link.serial_data_in      = sdata_ff;
  assign link.parallel_atten_bits = pbits_ff;
  assign o_done                   = done_ff;

endmodule

// File: rtl/sac_atten_dev.sv
// Purpose: control front end of a 7-bit 0.25 dB step attenuator
// Assumes: serial pins meet setup and hold around sclk rising edges
// Notes:   serial shifter runs on sclk, the applied word on i_mclk
`timescale 1ns/100ps

// Function
// - mode pin high is serial, low parallel
// - seven-bit word applied only when latch captures
// - serial data shifted msb first on sclk rise
// - controller raises latch after seven bits
// - latch high masks sclk; low while shifting
// - serial shifter active only in serial mode
// - controller drives every control pin always
// - serial mode: parallel bits driven low
// - parallel mode: serial pins driven low
// - msb is 16 dB, lsb 0.25 dB
// - quarter dB steps up to 31.75 dB
// - parallel mode has direct and latched forms
// - direct mode: latch high, bits pass through
// - latched mode: pulse latch, hold after fall
// - attenuation is sum of set stage weights
// - latch low at power up gives maximum
// - controller pulses latch once after power up
module sac_atten_dev
  import sac_pkg::*;
#(
  parameter int PWRUP_CYC = PWRUP_CYC_DFLT
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_b,
  sac_link_if.dev                    link,
  output logic [sac_pkg::ATTEN_W-1:0] o_atten_word,
  output logic [sac_pkg::QDB_W-1:0]   o_atten_qdb,
  output logic [sac_pkg::CDB_W-1:0]   o_atten_cdb,
  output logic                        o_atten_msb_16db,
  output logic                        o_atten_lsb_quarter_db,
  output logic                        o_settled,
  output logic                        o_pwrup_le_low
);
  import sac_pkg::*;

  // quarter-dB weight of one stage: binary from lsb upward
  function automatic logic [QDB_W-1:0] stage_qdb(input int idx);
    stage_qdb = QDB_W'(1) << idx;
  endfunction

  function automatic logic [QDB_W-1:0] word_qdb(
    input logic [ATTEN_W-1:0] w
  );
    logic [QDB_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < ATTEN_W; i++) begin
      if (w[i]) begin
        acc = acc + stage_qdb(i);
      end
    end
    word_qdb = acc;
  endfunction

  // link domain: shift register on the serial clock
  logic [ATTEN_W-1:0] shift_ff;
  logic [ATTEN_W-1:0] nxt_shift;
  wire                shift_en;

  // clock edges are masked whenever latch is high or mode is parallel
  assign shift_en  = link.ser_mode & ~link.latch_enable_in;
  // oldest of the last seven bits ends up at the msb
  assign nxt_shift = {shift_ff[ATTEN_W-2:0], link.serial_data_in};

  always_ff @(posedge link.sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_ff <= ATTEN_ZERO;
    end else if (shift_en) begin
      shift_ff <= nxt_shift;
    end
  end

  // system domain: two-flop synchronisers for the mode, latch and parallel pins
  localparam int SYN_W = ATTEN_W + 2;
  logic [SYN_W-1:0] meta_ff;
  logic [SYN_W-1:0] sync_ff;
  wire  [SYN_W-1:0] pins_raw;

  assign pins_raw = {link.ser_mode, link.latch_enable_in,
                     link.parallel_atten_bits};

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pins_raw;
      sync_ff <= meta_ff;
    end
  end

  wire                mode_s;
  wire                le_s;
  wire [ATTEN_W-1:0]  pbits_s;

  assign mode_s  = sync_ff[SYN_W-1];
  assign le_s    = sync_ff[SYN_W-2];
  assign pbits_s = sync_ff[ATTEN_W-1:0];

  // power-up window and strap capture of the latch pin
  logic [CNT_W-1:0] pwr_cnt_ff;
  logic [CNT_W-1:0] nxt_pwr_cnt;
  logic             settled_ff;
  logic             strap_taken_ff;
  logic             pwrup_le_low_ff;
  wire              strap_now;

  localparam logic [CNT_W-1:0] PWR_LOAD = CNT_W'(PWRUP_CYC);
  localparam logic [CNT_W-1:0] STRAP_AT = CNT_W'(PWRUP_CYC - SYNC_STAGES - 1);

  assign nxt_pwr_cnt = (pwr_cnt_ff != '0) ? pwr_cnt_ff - CNT_W'(1) : '0;
  // the synchroniser holds real pin levels by this count
  assign strap_now   = ~strap_taken_ff & (pwr_cnt_ff == STRAP_AT);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_cnt_ff      <= PWR_LOAD;
      settled_ff      <= 1'b0;
      strap_taken_ff  <= 1'b0;
      pwrup_le_low_ff <= 1'b0;
    end else begin
      pwr_cnt_ff <= nxt_pwr_cnt;
      settled_ff <= (nxt_pwr_cnt == '0);
      if (strap_now) begin
        strap_taken_ff  <= 1'b1;
        pwrup_le_low_ff <= ~le_s;
      end
    end
  end

  // word stays at maximum through the window unless le was high at start
  wire hold_max;
  assign hold_max = ~settled_ff &
                    ~(strap_taken_ff & ~pwrup_le_low_ff);

  // selection of the source word by the mode pin
  wire [ATTEN_W-1:0] src_word;
  // shift_ff is quiet while le is high, so it is safe to sample here
  assign src_word = mode_s ? shift_ff : pbits_s;

  // le high is transparent: held high gives direct mode,
  // a pulse gives latched mode with the word held after the fall
  wire load;
  assign load = le_s & ~hold_max;

  logic [ATTEN_W-1:0] word_ff;
  logic [QDB_W-1:0]   qdb_ff;
  logic [CDB_W-1:0]   cdb_ff;
  wire  [ATTEN_W-1:0] nxt_word;
  wire  [QDB_W-1:0]   nxt_qdb;
  wire  [CDB_W-1:0]   nxt_cdb;

  assign nxt_word = load ? src_word : word_ff;
  assign nxt_qdb  = word_qdb(nxt_word);
  // hundredths of a dB: 25 per quarter step, 3175 at full scale
  // widen both factors first so the product is not cut to eight bits
  assign nxt_cdb  = CDB_W'(nxt_qdb) * CDB_W'(CDB_PER_QDB);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      word_ff <= ATTEN_MAX;
      qdb_ff  <= QDB_W'(ATTEN_MAX);
      cdb_ff  <= CDB_W'(ATTEN_MAX) * CDB_W'(CDB_PER_QDB);
    end else begin
      word_ff <= nxt_word;
      qdb_ff  <= nxt_qdb;
      cdb_ff  <= nxt_cdb;
    end
  end

  assign o_atten_word           = word_ff;
  assign o_atten_qdb            = qdb_ff;
  assign o_atten_cdb            = cdb_ff;
  assign o_atten_msb_16db       = word_ff[ATTEN_MSB];
  assign o_atten_lsb_quarter_db = word_ff[ATTEN_LSB];
  assign o_settled              = settled_ff;
  assign o_pwrup_le_low         = pwrup_le_low_ff;

endmodule

// File: rtl/sac_link_if.sv
// Purpose: control pins between controller and attenuator
// Assumes: all pins are driven by the controller at all times
// Notes:   sclk is the link clock, made by the controller
`timescale 1ns/100ps
interface sac_link_if;
  logic       ser_mode;
  logic       latch_enable_in;
  logic       sclk;
  logic       serial_data_in;
  logic [6:0] parallel_atten_bits;

  modport ctrl (
    output ser_mode,
    output latch_enable_in,
    output sclk,
    output serial_data_in,
    output parallel_atten_bits
  );

  modport dev (
    input  ser_mode,
    input  latch_enable_in,
    input  sclk,
    input  serial_data_in,
    input  parallel_atten_bits
  );
endinterface

// File: rtl/sac_pkg.sv
// Purpose: shared constants for the step attenuator control port
// Assumes: system clock of 50 ns period on both ends
// Notes:   stage weights are in quarter-dB units
package sac_pkg;

  localparam int          ATTEN_W      = 7;
  localparam logic [6:0]  ATTEN_MAX    = 7'h7f;
  localparam logic [6:0]  ATTEN_ZERO   = 7'h00;
  localparam int          ATTEN_MSB    = 6;
  localparam int          ATTEN_LSB    = 0;
  localparam int          QDB_W        = 8;
  localparam int          CDB_W        = 12;
  localparam logic [4:0]  CDB_PER_QDB  = 5'h19;
  localparam int          SYNC_STAGES  = 2;

  localparam int          MCLK_NS      = 50;
  localparam int          SCK_MIN_NS   = 70;
  localparam int          LE_WIDTH_NS  = 10;
  localparam int          LE_SPACE_NS  = 630;
  localparam int          PWRUP_MS     = 200;

  localparam int SCK_HALF_RAW = (SCK_MIN_NS + 2 * MCLK_NS - 1) / (2 * MCLK_NS);
  localparam int SCK_HALF_CYC = (SCK_HALF_RAW > 0) ? SCK_HALF_RAW : 1;
  localparam int LE_WIDTH_RAW = (LE_WIDTH_NS + MCLK_NS - 1) / MCLK_NS;
  // the device sees le through a synchroniser, so the pulse must outlast it
  localparam int LE_HIGH_CYC  = (LE_WIDTH_RAW > SYNC_STAGES + 2) ?
                                LE_WIDTH_RAW : SYNC_STAGES + 2;
  localparam int LE_SPACE_RAW = (LE_SPACE_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int LE_SPACE_CYC = (LE_SPACE_RAW > 0) ? LE_SPACE_RAW : 1;
  localparam int PWRUP_CYC_DFLT = (PWRUP_MS * 1000000) / MCLK_NS;
  localparam int CNT_W        = $clog2(PWRUP_CYC_DFLT + 1);

  typedef enum logic {
    SAC_PARALLEL,
    SAC_SERIAL
  } sac_mode_t;

endpackage

// File: verif/sac_link_properties.sv
// Purpose: checks on the attenuator control link and applied word
// Assumes: both ends run on i_mclk; sclk comes from the controller
// Notes:   a shadow shifter on sclk mirrors what the device must hold
`timescale 1ns/100ps
module sac_link_properties
  import sac_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst_b,
  input wire logic        ser_mode,
  input wire logic        latch_enable_in,
  input wire logic        sclk,
  input wire logic        serial_data_in,
  input wire logic [6:0]  parallel_atten_bits,
  input wire logic [6:0]  o_atten_word,
  input wire logic [7:0]  o_atten_qdb,
  input wire logic [11:0] o_atten_cdb,
  input wire logic        o_atten_msb_16db,
  input wire logic        o_atten_lsb_quarter_db,
  input wire logic        o_settled
);
  logic [6:0] shadow_ff;

  always_ff @(posedge sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shadow_ff <= 7'h00;
    end else if (ser_mode && !latch_enable_in) begin
      shadow_ff <= {shadow_ff[5:0], serial_data_in};
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  sequence par_rise_s;
    $rose(latch_enable_in) && !ser_mode && o_settled;
  endsequence
  sequence par_held_s;
    (latch_enable_in && $stable(parallel_atten_bits))[*3];
  endsequence

  word_hold_a: assert property ((!latch_enable_in)[*4] |=>
    $stable(o_atten_word)) else $error("word moved without latch");
  par_load_a: assert property (par_rise_s ##1 par_held_s |->
    ##[0:2] (o_atten_word == parallel_atten_bits))
    else $error("parallel word not applied");
  ser_load_a: assert property (
    $rose(latch_enable_in) && ser_mode && o_settled |->
    ##[2:4] (o_atten_word == shadow_ff)) else $error("serial word lost");
  sclk_masked_a: assert property (latch_enable_in |-> !sclk)
    else $error("sclk moved while latch high");
  pbits_low_a: assert property (
    ser_mode |-> parallel_atten_bits == 7'h00)
    else $error("parallel bits set in serial mode");
  spins_low_a: assert property (
    !ser_mode |-> !sclk && !serial_data_in)
    else $error("serial pins set in parallel mode");
  qdb_sum_a: assert property (
    o_atten_qdb == {1'b0, o_atten_word}) else $error("qdb not word sum");
  cdb_scale_a: assert property (
    o_atten_cdb == 12'(o_atten_qdb) * 12'h019) else $error("cdb wrong");
  stage_bits_a: assert property (
    o_atten_msb_16db == o_atten_word[6] &&
    o_atten_lsb_quarter_db == o_atten_word[0]) else $error("stage bits");
endmodule

// File: verif/step_attenuator_control_port_tb.sv
// Purpose: bench for controller and device joined over the link
// Assumes: power-up window shortened to 20 cycles on every end
// Notes:   a second device is driven by hand to break the protocol
`timescale 1ns/100ps
module step_attenuator_control_port_tb;
  import sac_pkg::*;
  localparam int PW = 20;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        req_valid = 1'b0;
  logic [6:0]  req_word = 7'h00;
  sac_mode_t   req_mode = SAC_PARALLEL;
  logic        req_direct = 1'b0;
  logic        req_ready;
  logic        done;
  logic [6:0]  word;
  logic [7:0]  qdb;
  logic [11:0] cdb;
  logic        msb;
  logic        lsb;
  logic        settled;
  logic [6:0]  word2;
  logic        le_low2;
  logic        le_low;
  int          num_errors = 0;
  int          compares = 0;
  logic [31:0] seed = 32'ha08a16c6;
  logic [6:0]  exp_q[$];

  sac_link_if link();
  sac_link_if link2();
  sac_atten_ctrl #(.PWRUP_CYC(PW)) sac_atten_ctrl_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req_valid(req_valid),
    .i_req_word(req_word), .i_req_mode(req_mode),
    .i_req_direct(req_direct), .o_req_ready(req_ready),
    .o_done(done), .link(link));
  sac_atten_dev #(.PWRUP_CYC(PW)) sac_atten_dev_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(link),
    .o_atten_word(word), .o_atten_qdb(qdb), .o_atten_cdb(cdb),
    .o_atten_msb_16db(msb), .o_atten_lsb_quarter_db(lsb),
    .o_settled(settled), .o_pwrup_le_low(le_low));
  // second device sees a hand-driven link that breaks the rules
  sac_atten_dev #(.PWRUP_CYC(PW)) sac_atten_dev_inst2 (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(link2),
    .o_atten_word(word2), .o_atten_qdb(), .o_atten_cdb(),
    .o_atten_msb_16db(), .o_atten_lsb_quarter_db(),
    .o_settled(), .o_pwrup_le_low(le_low2));
  sac_link_properties sac_link_properties_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .ser_mode(link.ser_mode),
    .latch_enable_in(link.latch_enable_in), .sclk(link.sclk),
    .serial_data_in(link.serial_data_in),
    .parallel_atten_bits(link.parallel_atten_bits),
    .o_atten_word(word), .o_atten_qdb(qdb), .o_atten_cdb(cdb),
    .o_atten_msb_16db(msb), .o_atten_lsb_quarter_db(lsb),
    .o_settled(settled));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [6:0] w, input sac_mode_t m,
                      input logic d);
    int n;
    int e;
    n = 0;
    @(posedge i_mclk);
    req_valid <= 1'b1;
    req_word <= w;
    req_mode <= m;
    req_direct <= d;
    do begin
      @(negedge i_mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    @(posedge i_mclk);
    req_valid <= 1'b0;
    exp_q.push_back(w);
    do begin
      @(negedge i_mclk);
      n++;
    end while (done !== 1'b1 && n < 200);
    chk(12'(done), 12'h001);
    repeat (5) @(negedge i_mclk);
    e = exp_q.pop_front();
    chk(12'(word), 12'(e));
    chk(12'(qdb), 12'(e));
    chk(cdb, 12'(e * 25));
    chk(12'(msb), 12'((e >> 6) & 1));
    chk(12'(lsb), 12'(e & 1));
  endtask

  task automatic sh2(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link2.serial_data_in = v[i];
      #8 link2.sclk = 1'b1;
      #15 link2.sclk = 1'b0;
      #7;
    end
    // released data line falls to its pull-down level
    link2.serial_data_in = 1'b0;
  endtask

  task automatic latch2(input logic [6:0] exp);
    @(posedge i_mclk);
    link2.latch_enable_in <= 1'b1;
    repeat (5) @(posedge i_mclk);
    link2.latch_enable_in <= 1'b0;
    repeat (5) @(negedge i_mclk);
    chk(12'(word2), 12'(exp));
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end

  initial begin
    #300000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [6:0] w;
    link2.ser_mode = 1'b1;
    link2.latch_enable_in = 1'b0;
    link2.sclk = 1'b0;
    link2.serial_data_in = 1'b0;
    link2.parallel_atten_bits = 7'h00;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_mclk);
    sh2(9'h055, 7);
    latch2(7'h7f);
    chk(12'(word), 12'h07f);
    chk(12'(le_low2), 12'h001);
    chk(12'(le_low), 12'h001);
    chk(12'(settled), 12'h000);
    $display("test power-up ended");
    repeat (30) @(negedge i_mclk);
    chk(12'(word), 12'h000);
    chk(12'(settled), 12'h001);
    sh2(9'h1a5, 9);
    latch2(7'h25);
    @(posedge i_mclk);
    link2.latch_enable_in <= 1'b1;
    sh2(9'h07f, 7);
    latch2(7'h25);
    @(posedge i_mclk);
    link2.ser_mode <= 1'b0;
    link2.parallel_atten_bits <= 7'h11;
    sh2(9'h07f, 7);
    latch2(7'h11);
    @(posedge i_mclk);
    link2.ser_mode <= 1'b1;
    link2.parallel_atten_bits <= 7'h00;
    repeat (3) @(posedge i_mclk);
    latch2(7'h25);
    $display("test broken link ended");
    for (int k = 0; k < 36; k++) begin
      seed = xs(seed);
      w = (k == 0) ? 7'h7f : (k == 1) ? 7'h00 : seed[6:0];
      case ((k + seed[8]) % 3)
        0: send(w, SAC_SERIAL, 1'b0);
        1: send(w, SAC_PARALLEL, 1'b0);
        default: send(w, SAC_PARALLEL, 1'b1);
      endcase
    end
    $display("test request traffic ended");
    report_and_stop();
  end
endmodule
